// ===== test/tick_timer_calibration_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tick_timer_map.svh"

module tick_timer_calibration_tb_top;
   import tick_timer_pkg::*;
   // ==========================================================
   // bench signals
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd;
   logic [3:0]  pstrb;
   logic [2:0]  pprot;
   logic        pready, pslverr, ref_tick, no_reference_clock;
   logic        tick_request, prev_tick, err, use_ref;
   calib_t      calib_secure, calib_nonsecure, exp_c;
   int          miscompares, checked, seed, en_cnt, gap, ticks;
   `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
      miscompares++; $display("Error %s expected %h seen %h", nm, e, g); \
      end end

   tick_timer_calibration i_tick_timer_calibration (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ref_tick(ref_tick),
      .no_reference_clock(no_reference_clock), .calib_secure(calib_secure),
      .calib_nonsecure(calib_nonsecure), .tick_request(tick_request));

   // ==========================================================
   // clock and watchdog
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (100000) @(posedge pclk);
      miscompares++;
      print_verdict();
   end

   // counts counter steps between tick pulses; frozen cycles add none
   always @(posedge pclk) begin
      if (tick_request && !prev_tick) begin
         gap = en_cnt;
         ticks++;
         en_cnt = 0;
      end
      if (clk_en && (!use_ref || ref_tick)) en_cnt++;
      prev_tick = tick_request;
   end

   // ==========================================================
   // tasks
   task automatic print_verdict();
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // expected calibration word: reserved bits always read as zero
   function automatic logic [31:0] exp_calib(input logic nr,
      input calib_t c);
      return {nr, c.skew, 6'h00, c.ten_ms_reload};
   endfunction

   // one apb transfer; the leading edge keeps calls from colliding
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, input logic [2:0] p);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      pprot <= p;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         print_verdict();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h3d3e_10b0;
      {presetn, clk_en, psel, penable, pwrite, ref_tick, prev_tick} = '0;
      {paddr, pwdata, pstrb, pprot, no_reference_clock, use_ref} = '0;
      {calib_secure, calib_nonsecure} = '0;
      {miscompares, checked, en_cnt, ticks, gap} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      clk_en <= 1'b1;
      // calibration banks: ignored writes, then per-bank reads
      for (int i = 0; i < 8; i++) begin
         // first pass is the all-zero corner: no value known, secure bank
         rnd = (i == 0) ? 32'h0000_0000 : $random(seed);
         calib_secure <= rnd[24:0];
         calib_nonsecure <= rnd[31:7];
         no_reference_clock <= rnd[3];
         apb(1'b1, `TT_OFS_CALIB, ~rnd, 4'hF, {1'b0, rnd[5], 1'b0});
         `CHK("calib write err", 1'b0, err)
         apb(1'b0, `TT_OFS_CALIB, 32'h0000_0000, 4'hF, {1'b0, rnd[5], 1'b0});
         exp_c = rnd[5] ? rnd[31:7] : rnd[24:0];
         `CHK("calib", exp_calib(rnd[3], exp_c), rd)
      end
      // clock select forced to one without a reference clock
      for (int n = 1; n >= 0; n--) begin
         no_reference_clock <= n[0];
         // a one written without reference clock must not survive
         if (n[0]) apb(1'b1, `TT_OFS_CTRL, 32'h0000_0004, 4'hF, 3'h0);
         apb(1'b0, `TT_OFS_CTRL, 32'h0000_0000, 4'hF, 3'h0);
         `CHK("ctrl", {29'h0, n[0], 2'h0}, rd)
      end
      // refused accesses: unmapped read and partial write
      apb(1'b0, 12'h020, 32'h0000_0000, 4'hF, 3'h0);
      `CHK("unmapped", {1'b1, 32'h0000_0000}, {err, rd})
      apb(1'b1, `TT_OFS_RELOAD, 32'h0000_0055, 4'h3, 3'h0);
      `CHK("partial err", 1'b1, err)
      apb(1'b0, `TT_OFS_RELOAD, 32'h0000_0000, 4'hF, 3'h0);
      `CHK("reload kept", 32'h0000_0000, rd)
      // period of the tick under a randomly gated clock, both sources
      for (int s = 1; s >= 0; s--) begin
         use_ref <= !s[0];
         apb(1'b1, `TT_OFS_RELOAD, 32'h0000_0007, 4'hF, 3'h0);
         apb(1'b1, `TT_OFS_CURRENT, 32'h0000_0000, 4'hF, 3'h0);
         apb(1'b1, `TT_OFS_CTRL, {29'h0, s[0], 2'h3}, 4'hF, 3'h0);
         ticks = 0;
         for (int k = 0; k < 600 && ticks < 4; k++) begin
            @(posedge pclk);
            rnd = $random(seed);
            clk_en <= rnd[0];
            ref_tick <= rnd[1];
         end
         `CHK("tick period", 8, (ticks >= 4) ? gap : -1)
         @(posedge pclk);
         clk_en <= 1'b1;
         ref_tick <= 1'b0;
         apb(1'b1, `TT_OFS_CTRL, 32'h0000_0000, 4'hF, 3'h0);
      end
      print_verdict();
   end
endmodule // tick_timer_calibration_tb_top

`default_nettype wire

// ===== verilog/tick_timer_calibration.sv
// Function
// R1 - Calibration bit 31 reads 0 when a reference clock exists, 1 when not.
// R2 - Without a reference clock the clock select bit reads one, ignores writes.
// R3 - Calibration bit 30 reads 0 when the 10 ms figure is exact, else 1.
// R4 - Calibration bits 23:0 give the reload count for a 10 ms, 100 Hz tick.
// R5 - A zero 10 ms reload field means no calibration value is known.
// R6 - Each security state has its own calibration word, returned per state.
// R7 - The counter advances only on the enabled clock and holds when gated.
// R8 - Software uses full word accesses for all timer registers.
// R9 - Software writes reload, clears current, then writes control.
// R10 - Without calibration software derives reload from the clock frequency.
// R11 - Clock select 1 takes the processor clock, 0 the reference clock.
// R12 - The calibration word is read-only and bits 29:24 read as zero.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tick_timer_map.svh"

module tick_timer_calibration (
   // clock, reset and clock gate
   input  wire  logic                  pclk,
   input  wire  logic                  presetn,
   input  wire  logic                  clk_en,
   // apb slave
   input  wire  logic                  psel,
   input  wire  logic                  penable,
   input  wire  logic                  pwrite,
   input  wire  logic [11:0]           paddr,
   input  wire  logic [31:0]           pwdata,
   input  wire  logic [3:0]            pstrb,
   input  wire  logic [2:0]            pprot,
   output var   logic [31:0]           prdata,
   output var   logic                  pready,
   output var   logic                  pslverr,
   // reference clock and calibration straps
   input  wire  logic                  ref_tick,
   input  wire  logic                  no_reference_clock,
   input  wire  tick_timer_pkg::calib_t calib_secure,
   input  wire  tick_timer_pkg::calib_t calib_nonsecure,
   // timer event
   output var   logic                  tick_request
);
   import tick_timer_pkg::*;

   // ========================================================================
   // state
   bus_state_t  bus_q, bus_d;
   logic        pready_q, pready_d;
   logic        pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   ctrl_t       ctrl_q, ctrl_d;
   logic        flag_q, flag_d;
   logic [23:0] reload_q, reload_d;
   logic [23:0] current_q, current_d;
   logic        tick_q, tick_d;

   // ========================================================================
   // decode
   logic   fire, rd_fire, wr_fire, hit_ctrl, hit_rel, hit_cur, hit_cal;
   logic   clksel_eff, step, zero_hit;
   calib_t cal_sel;
   logic [31:0] rd_mux;

   assign fire     = psel && penable && pready_q;
   assign rd_fire  = fire && !pwrite && !pslverr_q;
   assign wr_fire  = fire && pwrite && !pslverr_q;
   assign hit_ctrl = (paddr == `TT_OFS_CTRL);
   assign hit_rel  = (paddr == `TT_OFS_RELOAD);
   assign hit_cur  = (paddr == `TT_OFS_CURRENT);
   assign hit_cal  = (paddr == `TT_OFS_CALIB);
   // pprot[1] high marks a non-secure access
   assign cal_sel  = pprot[1] ? calib_nonsecure : calib_secure; // R6
   // no reference clock pins the source to the processor clock
   assign clksel_eff = ctrl_q.clksel || no_reference_clock; // R2 R11
   // reference path advances only on a reference tick
   assign step = ctrl_q.enable && (clksel_eff || ref_tick); // R11
   assign zero_hit = step && (current_q == 24'h00_0001);

   // read mux
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[`TT_CTRL_COUNTFLAG] = flag_q;
         rd_mux[`TT_CTRL_CLKSEL]    = clksel_eff; // R2
         rd_mux[`TT_CTRL_TICKINT]   = ctrl_q.tickint;
         rd_mux[`TT_CTRL_ENABLE]    = ctrl_q.enable;
      end else if (hit_rel) begin
         rd_mux[23:0] = reload_q;
      end else if (hit_cur) begin
         rd_mux[23:0] = current_q;
      end else if (hit_cal) begin
         // reserved 29:24 stay zero; a zero field means no value known
         rd_mux[`TT_CAL_NO_REF] = no_reference_clock; // R1
         rd_mux[`TT_CAL_SKEW]  = cal_sel.skew; // R3
         rd_mux[23:0]          = cal_sel.ten_ms_reload; // R4 R5 R12
      end
   end

   // ========================================================================
   // apb slave: one wait state, data captured on the edge that raises pready
   always_comb begin
      bus_d     = bus_q;
      pready_d  = 1'b0;
      pslverr_d = 1'b0;
      prdata_d  = prdata_q;
      case (bus_q)
         BUS_IDLE: begin
            if (psel && penable) begin
               bus_d     = BUS_DONE;
               pready_d  = 1'b1;
               prdata_d  = pwrite ? 32'h0000_0000 : rd_mux;
               // partial or unmapped accesses are refused, never applied
               pslverr_d = !(hit_ctrl || hit_rel || hit_cur || hit_cal) ||
                           (pwrite && pstrb != `TT_FULL_STRB); // R8
            end
         end
         BUS_DONE: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_q     <= BUS_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clk_en) begin
         bus_q     <= bus_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // ========================================================================
   // timer registers and counter
   always_comb begin
      ctrl_d    = ctrl_q;
      reload_d  = reload_q;
      current_d = current_q;
      flag_d    = flag_q;
      tick_d    = 1'b0;
      if (step) begin
         current_d = (current_q == `TT_COUNT_RESET) ? reload_q
                                                    : current_q - 24'h00_0001;
      end
      if (wr_fire && hit_ctrl) begin
         // without a reference clock the select write is dropped, so a
         // later reference clock never picks up a stale software choice
         ctrl_d.enable  = pwdata[`TT_CTRL_ENABLE];
         ctrl_d.tickint = pwdata[`TT_CTRL_TICKINT];
         if (!no_reference_clock) begin // R2
            ctrl_d.clksel = pwdata[`TT_CTRL_CLKSEL]; // R11
         end
      end
      if (wr_fire && hit_rel) begin
         reload_d = pwdata[23:0];
      end
      if (wr_fire && hit_cur) begin
         current_d = `TT_COUNT_RESET;
         flag_d    = 1'b0;
      end
      // clear only a flag that the read returned: a set landing between
      // data capture and completion would otherwise be lost unseen
      if (rd_fire && hit_ctrl && prdata_q[`TT_CTRL_COUNTFLAG]) begin
         flag_d = 1'b0;
      end
      // reaching zero beats a same-cycle clear
      if (zero_hit) begin
         flag_d = 1'b1;
         tick_d = ctrl_q.tickint;
      end
   end

   // gated clock_en freezes the counter like a stopped clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q    <= `TT_CTRL_RESET;
         reload_q  <= `TT_COUNT_RESET;
         current_q <= `TT_COUNT_RESET;
         flag_q    <= 1'b0;
         tick_q    <= 1'b0;
      end else if (clk_en) begin // R7
         ctrl_q    <= ctrl_d;
         reload_q  <= reload_d;
         current_q <= current_d;
         flag_q    <= flag_d;
         tick_q    <= tick_d;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign tick_request = tick_q;

   // ========================================================================
   // assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // first access cycle of a read: prdata_q is loaded at this edge
   logic cal_take, csr_take;
   assign cal_take = clk_en && psel && penable && !pready_q && !pwrite &&
                     hit_cal;
   assign csr_take = clk_en && psel && penable && !pready_q && !pwrite &&
                     hit_ctrl;

   cal_reserved_a: assert property (cal_take |=> // R12
      prdata_q[`TT_CAL_RSVD_HI:`TT_CAL_RSVD_LO] == 6'h00)
      else $error("calibration reserved bits not zero");
   cal_no_reference_clock_a: assert property (cal_take |=> // R1
      prdata_q[`TT_CAL_NO_REF] == $past(no_reference_clock))
      else $error("reference flag mismatch");
   cal_skew_a: assert property (cal_take |=> // R3
      prdata_q[`TT_CAL_SKEW] == $past(cal_sel.skew))
      else $error("skew flag mismatch");
   cal_reload_a: assert property (cal_take |=> // R4
      prdata_q[23:0] == $past(cal_sel.ten_ms_reload))
      else $error("ten ms field or bank mismatch");
   csr_force_a: assert property (csr_take && no_reference_clock |=> // R2
      prdata_q[`TT_CTRL_CLKSEL])
      else $error("clock select not forced to one");
   clksel_keep_a: assert property (wr_fire && hit_ctrl && // R2
      no_reference_clock |=> ctrl_q.clksel == $past(ctrl_q.clksel))
      else $error("clock select write not discarded");
   gate_freeze_a: assert property (!clk_en |=> // R7
      $stable(current_q) && $stable(flag_q) && $stable(ctrl_q))
      else $error("state moved while clock gated");
   ref_hold_a: assert property (clk_en && ctrl_q.enable && // R11
      !clksel_eff && !ref_tick && !(wr_fire && hit_cur) |=>
      $stable(current_q))
      else $error("counter moved without reference tick");
   wrap_reload_a: assert property (clk_en && step && // R11
      current_q == 24'h00_0000 && !wr_fire |=>
      current_q == $past(reload_q))
      else $error("counter did not reload at zero");

   cal_read_c: cover property (rd_fire && hit_cal && pprot[1]);
   zero_tick_c: cover property (clk_en && zero_hit && ctrl_q.tickint);
   ref_step_c: cover property (clk_en && step && !clksel_eff);
   bad_strb_c: cover property (pready_q && pslverr_q);

endmodule // tick_timer_calibration

`default_nettype wire

// ===== verilog/tick_timer_map.svh
`ifndef TICK_TIMER_MAP_SVH
`define TICK_TIMER_MAP_SVH
// ==========================================================================
// register offsets (byte addresses, low bits of paddr)
`define TT_ADDR_W          12
`define TT_OFS_CTRL        12'h010
`define TT_OFS_RELOAD      12'h014
`define TT_OFS_CURRENT     12'h018
`define TT_OFS_CALIB       12'h01C
// ==========================================================================
// control and status field positions
`define TT_CTRL_ENABLE     0
`define TT_CTRL_TICKINT    1
`define TT_CTRL_CLKSEL     2
`define TT_CTRL_COUNTFLAG  16
// ==========================================================================
// calibration word field positions
`define TT_CAL_NO_REF      31
`define TT_CAL_SKEW        30
`define TT_CAL_RSVD_HI     29
`define TT_CAL_RSVD_LO     24
// ==========================================================================
// reset values and constants
`define TT_CTRL_RESET      3'h0
`define TT_COUNT_RESET     24'h00_0000
`define TT_FULL_STRB       4'hF
`define TT_APB_WAIT        1
`endif

// ===== verilog/tick_timer_pkg.sv
`default_nettype none
package tick_timer_pkg;
   // calibration content of one security state
   typedef struct packed {
      logic        skew;
      logic [23:0] ten_ms_reload;
   } calib_t;
   // control bits kept in flops
   typedef struct packed {
      logic clksel;
      logic tickint;
      logic enable;
   } ctrl_t;
   // bus slave phase
   typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;
endpackage
`default_nettype wire
